// *** src/encoder_pkg.sv ***
/*
 * Shared constants for the code hopping encoder control core: store word
 * indices, option word fields, state codes and timing counts.
 * Assumes a single 125 MHz core clock and byte addresses of four per word.
 */
package encoder_pkg;

    // ------------------------------------------------------------------
    // store layout
    // ------------------------------------------------------------------
    localparam int STORE_WORDS = 12;
    localparam int WORD_W = 16;
    localparam logic [3:0] IDX_KEY0 = 4'h0;
    localparam logic [3:0] IDX_KEY1 = 4'h1;
    localparam logic [3:0] IDX_KEY2 = 4'h2;
    localparam logic [3:0] IDX_KEY3 = 4'h3;
    localparam logic [3:0] IDX_COUNTER = 4'h4;
    localparam logic [3:0] IDX_SPARE_A = 4'h5;
    localparam logic [3:0] IDX_IDENT_LO = 4'h6;
    localparam logic [3:0] IDX_IDENT_HI = 4'h7;
    localparam logic [3:0] IDX_LEARN_LO = 4'h8;
    localparam logic [3:0] IDX_LEARN_HI = 4'h9;
    localparam logic [3:0] IDX_SPARE_B = 4'ha;
    localparam logic [3:0] IDX_OPTION = 4'hb;
    localparam logic [3:0] IDX_STATUS = 4'hc;
    localparam logic [3:0] IDX_LIMIT = 4'hc;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] COUNTER_TOP = 16'hffff;

    // ------------------------------------------------------------------
    // option word and identity fields
    // ------------------------------------------------------------------
    localparam int OPT_DISC_MSB = 9;
    localparam int OPT_OVERFLOW_FLAG_FIRST = 10;
    localparam int OPT_OVERFLOW_FLAG_SECOND = 11;
    localparam int OPT_TRIP_SEL = 12;
    localparam int OPT_RATE_LO = 13;
    localparam int OPT_RATE_HI = 14;
    localparam int IDENT_HI_SHUTOFF = 15;
    localparam int IDENT_TX_HI_MSB = 11;
    localparam logic [1:0] RATE_400US = 2'h0;
    localparam logic [1:0] RATE_200US = 2'h1;
    localparam logic [1:0] RATE_100US_HALF = 2'h2;
    localparam logic [1:0] BLANK_NONE = 2'h0;
    localparam logic [1:0] BLANK_HALF = 2'h1;
    localparam logic [1:0] BLANK_QUARTER = 2'h3;
    localparam logic [3:0] BUTTONS_ALL = 4'hf;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_HZ = 125_000_000;
    localparam longint unsigned DEBOUNCE_MS = 10;
    localparam longint unsigned AUTO_OFF_S = 25;
    localparam longint unsigned BLINK_HALF_MS = 100;
    localparam longint unsigned DEBOUNCE_CYC = CLK_HZ * DEBOUNCE_MS / 1000;
    localparam longint unsigned AUTO_OFF_CYC = CLK_HZ * AUTO_OFF_S;
    localparam longint unsigned BLINK_HALF_CYC = CLK_HZ * BLINK_HALF_MS / 1000;

    // ------------------------------------------------------------------
    // control states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEBOUNCE = 3'b001,
        ST_COUNT = 3'b010,
        ST_CIPHER = 3'b011,
        ST_SEND = 3'b100,
        ST_TIMEOUT = 3'b101
    } enc_state_t;

    // blanking mask for a rate pair: a word is sent when index & mask is zero
    function automatic logic [1:0] blank_mask(input logic [1:0] rate);
        logic [1:0] m;
        m = BLANK_QUARTER;
        if (rate == RATE_400US) begin
            m = BLANK_NONE;
        end else if (rate == RATE_200US || rate == RATE_100US_HALF) begin
            m = BLANK_HALF;
        end
        return m;
    endfunction : blank_mask

endpackage : encoder_pkg

// *** src/hopping_encoder_control_store.sv ***
/*
 * Control core of a button woken code hopping encoder with its twelve word
 * parameter store reached over APB. Assumes an external 32-bit cipher on the
 * same clock and an external bit modulator that pulses word_done per word.
 */
// Chosen here: register access over APB.
module hopping_encoder_control_store
    import encoder_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = 32'(DEBOUNCE_CYC),
    parameter int unsigned AUTO_OFF_CYCLES = 32'(AUTO_OFF_CYC),
    parameter int unsigned BLINK_CYCLES = 32'(BLINK_HALF_CYC)
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic button_in_0,
    input wire logic button_in_1,
    input wire logic button_in_2,
    input wire logic button_in_3,
    input wire logic battery_low,
    output logic cipher_req,
    output logic [31:0] cipher_plain,
    output logic [63:0] cipher_key,
    input wire logic cipher_done,
    input wire logic [31:0] cipher_result,
    output logic word_valid,
    output logic word_blank,
    output logic [65:0] code_word,
    input wire logic word_done,
    output logic [1:0] pulse_element_sel,
    output logic battery_trip_select,
    output logic indicator_sink_n
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] store_ff [STORE_WORDS];
    enc_state_t state_ff, nxt_state;
    logic [3:0] btn_meta_ff, btn_sync_ff, btn_held_ff;
    logic [1:0] batt_meta_ff;
    logic batt_sync_ff, vlow_ff, rpt_ff, blink_ff, cipher_req_ff, blank_ff, led_n_ff;
    logic [31:0] deb_cnt_ff, off_cnt_ff, blink_cnt_ff, hop_ff, prdata_ff;
    logic [1:0] word_idx_ff;
    logic [15:0] option_w, ident_hi_w, counter_w;
    logic any_btn, new_btn, active_tx, restart, deb_done, is_seed, shutoff_en, shutoff_hit;
    logic apb_setup, apb_access, addr_ok, hit_store, hit_status, store_wr, hw_step, wrap;
    logic [3:0] reg_idx;
    logic [31:0] status_word;
    logic [1:0] rate;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    // two flops for the buttons, three for the battery comparator
    always_ff @(posedge core_clk) begin
        if (rst) begin
            btn_meta_ff <= 4'h0;
            btn_sync_ff <= 4'h0;
            batt_meta_ff <= 2'h0;
            batt_sync_ff <= 1'b0;
        end else begin
            btn_meta_ff <= {button_in_3, button_in_2, button_in_1, button_in_0};
            btn_sync_ff <= btn_meta_ff;
            batt_meta_ff <= {batt_meta_ff[0], battery_low};
            batt_sync_ff <= batt_meta_ff[1];
        end
    end

    // ------------------------------------------------------------------
    // decode of store fields and button events
    // ------------------------------------------------------------------
    assign option_w = store_ff[IDX_OPTION];
    assign ident_hi_w = store_ff[IDX_IDENT_HI];
    assign counter_w = store_ff[IDX_COUNTER];
    assign rate = {option_w[OPT_RATE_HI], option_w[OPT_RATE_LO]};
    assign shutoff_en = ident_hi_w[IDENT_HI_SHUTOFF];
    assign any_btn = |btn_sync_ff;
    assign new_btn = |(btn_sync_ff & ~btn_held_ff);
    assign active_tx = (state_ff == ST_COUNT) || (state_ff == ST_CIPHER) || (state_ff == ST_SEND);
    assign restart = active_tx && new_btn;
    assign deb_done = (state_ff == ST_DEBOUNCE) && (deb_cnt_ff == DEBOUNCE_CYCLES - 1);
    assign is_seed = (btn_held_ff == BUTTONS_ALL);
    assign shutoff_hit = shutoff_en && (off_cnt_ff == AUTO_OFF_CYCLES - 1);
    assign hw_step = (state_ff == ST_COUNT) && !restart;
    assign wrap = (counter_w == COUNTER_TOP);

    // ------------------------------------------------------------------
    // control state machine
    // ------------------------------------------------------------------
    // next state; an added button in count, cipher or send overrides everything and re-debounces
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (any_btn) begin
                    nxt_state = ST_DEBOUNCE;
                end
            end
            ST_DEBOUNCE: begin
                if (deb_done) begin
                    nxt_state = any_btn ? ST_COUNT : ST_IDLE;
                end
            end
            ST_COUNT: begin
                nxt_state = is_seed ? ST_SEND : ST_CIPHER;
            end
            ST_CIPHER: begin
                if (cipher_done) begin
                    nxt_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (shutoff_hit) begin
                    nxt_state = ST_TIMEOUT;
                end else if (word_done && !any_btn) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_TIMEOUT: begin
                if (!any_btn) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (restart) begin
            nxt_state = ST_DEBOUNCE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // debounce, shutoff and blink timers
    // ------------------------------------------------------------------
    // debounce counts only inside its state; shutoff counts from count state until release, restarting on an added button
    always_ff @(posedge core_clk) begin
        if (rst) begin
            deb_cnt_ff <= 32'h0;
            off_cnt_ff <= 32'h0;
        end else begin
            deb_cnt_ff <= (state_ff == ST_DEBOUNCE && !deb_done) ? deb_cnt_ff + 32'h1 : 32'h0;
            if (!active_tx || restart) begin
                off_cnt_ff <= 32'h0;
            end else if (shutoff_en && !shutoff_hit) begin
                off_cnt_ff <= off_cnt_ff + 32'h1;
            end
        end
    end

    // about 5 Hz toggle used when the battery is low
    always_ff @(posedge core_clk) begin
        if (rst || !active_tx) begin
            blink_cnt_ff <= 32'h0;
            blink_ff <= 1'b0;
        end else if (blink_cnt_ff == BLINK_CYCLES - 1) begin
            blink_cnt_ff <= 32'h0;
            blink_ff <= ~blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // transmission data
    // ------------------------------------------------------------------
    // sample buttons after debounce; latch hopping part and status bits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            btn_held_ff <= 4'h0;
            hop_ff <= 32'h0;
            cipher_req_ff <= 1'b0;
            rpt_ff <= 1'b0;
            vlow_ff <= 1'b0;
            word_idx_ff <= 2'h0;
        end else begin
            cipher_req_ff <= (state_ff == ST_COUNT) && (nxt_state == ST_CIPHER);
            if (deb_done) begin
                btn_held_ff <= btn_sync_ff;
            end else if (state_ff == ST_IDLE) begin
                btn_held_ff <= 4'h0;
            end
            if (hw_step && is_seed) begin
                hop_ff <= {store_ff[IDX_LEARN_HI], store_ff[IDX_LEARN_LO]};
            end else if (state_ff == ST_CIPHER && cipher_done) begin
                hop_ff <= cipher_result;
            end
            if (hw_step) begin
                rpt_ff <= 1'b0;
                vlow_ff <= batt_sync_ff;
                word_idx_ff <= 2'h0;
            end else if (state_ff == ST_SEND && word_done) begin
                rpt_ff <= 1'b1;
                vlow_ff <= batt_sync_ff;
                word_idx_ff <= word_idx_ff + 2'h1;
            end
        end
    end

    // blank flag and indicator drive come from flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            blank_ff <= 1'b0;
            led_n_ff <= 1'b1;
        end else begin
            blank_ff <= |(word_idx_ff & blank_mask(rate));
            led_n_ff <= ~(active_tx && (!vlow_ff || blink_ff));
        end
    end

    // plaintext: buttons, two overflow flags, discrimination, counter
    assign cipher_plain = {btn_held_ff, option_w[OPT_OVERFLOW_FLAG_SECOND:OPT_OVERFLOW_FLAG_FIRST],
                           option_w[OPT_DISC_MSB:0], counter_w};
    assign cipher_key = {store_ff[IDX_KEY3], store_ff[IDX_KEY2],
                         store_ff[IDX_KEY1], store_ff[IDX_KEY0]};
    assign cipher_req = cipher_req_ff;
    // fixed part: low battery, repeat, buttons, 28 identity bits
    assign code_word = {vlow_ff, rpt_ff, btn_held_ff, ident_hi_w[IDENT_TX_HI_MSB:0],
                        store_ff[IDX_IDENT_LO], hop_ff};
    assign word_valid = (state_ff == ST_SEND);
    assign word_blank = blank_ff;
    assign pulse_element_sel = rate;
    assign battery_trip_select = option_w[OPT_TRIP_SEL];
    assign indicator_sink_n = led_n_ff;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // zero wait answer; store words are write only and read as zero
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign reg_idx = paddr[5:2];
    assign addr_ok = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
    assign hit_store = addr_ok && (reg_idx < IDX_LIMIT);
    assign hit_status = addr_ok && (reg_idx == IDX_STATUS);
    assign store_wr = apb_access && pwrite && hit_store;
    assign status_word = {23'h0, state_ff == ST_TIMEOUT, rpt_ff, btn_held_ff, state_ff};
    assign pready = 1'b1;
    assign pslverr = apb_access && !(hit_store || hit_status);
    assign prdata = prdata_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata_ff <= 32'h0;
        end else if (apb_setup) begin
            prdata_ff <= (hit_status && !pwrite) ? status_word : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // parameter store
    // ------------------------------------------------------------------
    // the counter step wins over a software write in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < STORE_WORDS; i++) begin
                store_ff[i] <= WORD_RESET;
            end
        end else begin
            if (store_wr) begin
                store_ff[reg_idx] <= pwdata[WORD_W-1:0];
            end
            if (hw_step) begin
                store_ff[IDX_COUNTER] <= counter_w + 16'h1;
                if (wrap && option_w[OPT_OVERFLOW_FLAG_FIRST]) begin
                    store_ff[IDX_OPTION][OPT_OVERFLOW_FLAG_FIRST] <= 1'b0;
                end else if (wrap) begin
                    store_ff[IDX_OPTION][OPT_OVERFLOW_FLAG_SECOND] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_tx_start;
        state_ff == ST_COUNT && !restart;
    endsequence

    sequence s_last_word;
        state_ff == ST_SEND && word_done && !any_btn && !shutoff_hit && !new_btn;
    endsequence

    sequence s_seed_start;
        state_ff == ST_COUNT && !restart && is_seed;
    endsequence

    wake_idle_a: assert property (state_ff == ST_IDLE && any_btn |=> state_ff == ST_DEBOUNCE)
        else $error("idle did not wake on a button");
    debounce_len_a: assert property ($rose(state_ff == ST_COUNT) |->
        $past(state_ff) == ST_DEBOUNCE && $past(deb_cnt_ff) == DEBOUNCE_CYCLES - 1)
        else $error("transmission started before debounce ended");
    plain_fields_a: assert property (cipher_req |-> cipher_plain[15:0] == counter_w
        && cipher_plain[31:28] == btn_held_ff && cipher_plain[25:16] == option_w[9:0])
        else $error("cipher input fields wrong");
    count_step_a: assert property (s_tx_start |=> counter_w == $past(counter_w) + 16'h1)
        else $error("counter not advanced once");
    added_button_a: assert property (restart |=> state_ff == ST_DEBOUNCE && !word_valid)
        else $error("added button did not abort");
    finish_word_a: assert property (state_ff == ST_SEND && !word_done && !restart
        && !shutoff_hit |=> state_ff == ST_SEND)
        else $error("word cut before completion");
    power_down_a: assert property (s_last_word |=> state_ff == ST_IDLE)
        else $error("no power down after release");
    learn_send_a: assert property (word_valid && is_seed |->
        code_word[31:0] == {store_ff[IDX_LEARN_HI], store_ff[IDX_LEARN_LO]})
        else $error("learn value not sent");
    serial_part_a: assert property (code_word[59:32] ==
        {ident_hi_w[11:0], store_ff[IDX_IDENT_LO]})
        else $error("identity field wrong");
    shutoff_a: assert property (shutoff_hit && state_ff == ST_SEND && !restart
        |=> state_ff == ST_TIMEOUT ##1 !word_valid)
        else $error("shutoff did not stop sending");
    overflow_a: assert property (hw_step && wrap && option_w[OPT_OVERFLOW_FLAG_FIRST]
        |=> !option_w[OPT_OVERFLOW_FLAG_FIRST] && option_w[OPT_OVERFLOW_FLAG_SECOND] == $past(option_w[OPT_OVERFLOW_FLAG_SECOND]))
        else $error("first wrap did not clear first flag");
    full_rate_a: assert property (word_valid && rate == RATE_400US && $stable(rate)
        |-> ##1 !word_blank)
        else $error("blanking at full rate");

    // seed path, second wrap, held buttons and timeout hold
    seed_direct_a: assert property (s_seed_start
        |=> state_ff == ST_SEND && !cipher_req)
        else $error("seed word went through the cipher");
    second_wrap_a: assert property (hw_step && wrap && !option_w[OPT_OVERFLOW_FLAG_FIRST]
        |=> !option_w[OPT_OVERFLOW_FLAG_SECOND])
        else $error("second wrap did not clear second flag");
    button_keep_a: assert property (word_valid && !restart
        |=> !word_valid || $stable(btn_held_ff))
        else $error("sent buttons changed mid transmission");
    timeout_hold_a: assert property (state_ff == ST_TIMEOUT && any_btn
        |=> state_ff == ST_TIMEOUT)
        else $error("timeout left while button held");

endmodule : hopping_encoder_control_store

// *** test/far_side_model.sv ***
/*
 * Behavioural stand-in for the external cipher and bit modulator.
 * Assumes the control core's clock and one-cycle request and done pulses.
 */
module far_side_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cipher_req,
    input wire logic [31:0] cipher_plain,
    output logic cipher_done,
    output logic [31:0] cipher_result,
    input wire logic word_valid,
    output logic word_done,
    output logic [31:0] plain_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cdly_ff;
    logic slow_ff;
    logic [2:0] wcnt_ff;
    // ------------------------------------------------------------------
    // cipher answers fast and slow in turn; result only valid with done
    // ------------------------------------------------------------------
    initial begin
        cipher_done = 1'b0;
        word_done = 1'b0;
        cipher_result = 32'h0000_0000;
        plain_seen = 32'h0000_0000;
    end
    always @(posedge core_clk) begin
        cipher_done <= 1'b0;
        word_done <= 1'b0;
        cipher_result <= ~cipher_result; // stale value never lingers
        if (rst) begin
            cdly_ff <= 3'h0;
            slow_ff <= 1'b0;
            wcnt_ff <= 3'h0;
        end else begin
            if (cipher_req) begin
                plain_seen <= cipher_plain;
                cdly_ff <= slow_ff ? 3'h5 : 3'h1;
                slow_ff <= ~slow_ff;
            end else if (cdly_ff == 3'h1) begin
                cipher_done <= 1'b1;
                cipher_result <= plain_seen ^ 32'h5a5a_a5a5;
                cdly_ff <= 3'h0;
            end else if (cdly_ff != 3'h0) begin
                cdly_ff <= cdly_ff - 3'h1;
            end
            // modulator closes a word slot every six cycles
            if (word_valid && wcnt_ff == 3'h5) begin
                word_done <= 1'b1;
                wcnt_ff <= 3'h0;
            end else begin
                wcnt_ff <= word_valid ? wcnt_ff + 3'h1 : 3'h0;
            end
        end
    end
endmodule : far_side_model

// *** test/tb_hopping_encoder_control_store.sv ***
/*
 * Self-checking bench for the encoder control core: APB store access,
 * transmissions, seed, abort and auto shutoff. Assumes the far side model.
 */
module tb_hopping_encoder_control_store;
    import encoder_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, cipher_plain, cipher_result, plain_seen;
    logic [3:0] btn;
    logic battery_low, cipher_req, cipher_done, word_valid, word_blank, word_done;
    logic [63:0] cipher_key;
    logic [65:0] code_word;
    logic [1:0] pulse_element_sel;
    logic battery_trip_select, indicator_sink_n;
    int fails = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic er;

    hopping_encoder_control_store #(.DEBOUNCE_CYCLES(20), .AUTO_OFF_CYCLES(200),
        .BLINK_CYCLES(8)) dut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .button_in_0(btn[0]),
        .button_in_1(btn[1]), .button_in_2(btn[2]), .button_in_3(btn[3]),
        .battery_low(battery_low), .cipher_req(cipher_req), .cipher_plain(cipher_plain),
        .cipher_key(cipher_key), .cipher_done(cipher_done), .cipher_result(cipher_result),
        .word_valid(word_valid), .word_blank(word_blank), .code_word(code_word),
        .word_done(word_done), .pulse_element_sel(pulse_element_sel),
        .battery_trip_select(battery_trip_select), .indicator_sink_n(indicator_sink_n));
    far_side_model partner (.core_clk(core_clk), .rst(rst), .cipher_req(cipher_req),
        .cipher_plain(cipher_plain), .cipher_done(cipher_done),
        .cipher_result(cipher_result), .word_valid(word_valid), .word_done(word_done),
        .plain_seen(plain_seen));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h30, 16'h0000);
            n++;
        end while (rd[2:0] !== s && n < 600);
        chk(rd[2:0], s);
    endtask : wait_state
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #(50_000 * 8);
        fails++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        btn = 4'h0;
        battery_low = 1'b0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, 8'h00, 16'h0000);
        chk({er, rd}, 33'h0);
        apb(1'b0, 8'h34, 16'h0000);
        chk(er, 1'b1);
        for (int i = 0; i < 4; i++) apb(1'b1, 8'(i * 4), 16'(16'h1111 * (i + 1)));
        apb(1'b1, 8'h10, 16'hffff);
        apb(1'b1, 8'h14, 16'h0000);
        apb(1'b1, 8'h28, 16'h0000);
        apb(1'b1, 8'h18, 16'h1234);
        apb(1'b1, 8'h1c, 16'h0abc);
        apb(1'b1, 8'h20, 16'hbeef);
        apb(1'b1, 8'h24, 16'h0123);
        apb(1'b1, 8'h2c, 16'h7e34);
        @(posedge core_clk);
        chk(cipher_key, 64'h4444_3333_2222_1111);
        chk({pulse_element_sel, battery_trip_select}, 3'b111);
        // two presses of one button: counter wraps, first flag clears
        for (int p = 0; p < 2; p++) begin
            btn <= 4'h1;
            wait_state(3'h4);
            chk(plain_seen, {4'h1, 2'b10, 10'h234, 16'(p)});
            chk(code_word[63:0], {4'h1, 28'habc1234, 32'({4'h1, 2'b10, 10'h234, 16'(p)}
                ^ 32'h5a5a_a5a5)});
            chk(indicator_sink_n, 1'b0);
            do @(posedge core_clk); while (word_done !== 1'b1);
            repeat (2) @(posedge core_clk);
            chk(word_blank, 1'b1);
            btn <= 4'h0;
            wait_state(3'h0);
            chk(indicator_sink_n, 1'b1);
        end
        // seed on all buttons, repeat and low battery flagged
        battery_low <= 1'b1;
        btn <= 4'hf;
        wait_state(3'h4);
        repeat (20) @(posedge core_clk);
        chk(code_word, {2'b11, 4'hf, 28'habc1234, 32'h0123_beef});
        btn <= 4'h0;
        battery_low <= 1'b0;
        wait_state(3'h0);
        // added button mid transmission restarts; a second wrap clears the second flag
        apb(1'b1, 8'h10, 16'hffff);
        btn <= 4'h1;
        wait_state(3'h4);
        btn <= 4'h3;
        wait_state(3'h1);
        wait_state(3'h4);
        chk(rd[6:3], 4'h3);
        chk(plain_seen, {4'h3, 2'b00, 10'h234, 16'h0001});
        btn <= 4'h0;
        wait_state(3'h0);
        // shutoff enabled: held button ends in timeout, sending stops
        apb(1'b1, 8'h1c, 16'h8abc);
        apb(1'b1, 8'h2c, 16'h1234);
        @(posedge core_clk);
        chk({pulse_element_sel, battery_trip_select}, 3'b001);
        btn <= 4'h2;
        wait_state(3'h4);
        do @(posedge core_clk); while (word_done !== 1'b1);
        repeat (2) @(posedge core_clk);
        chk(word_blank, 1'b0);
        wait_state(3'h5);
        chk({word_valid, rd[8]}, 2'b01);
        btn <= 4'h0;
        wait_state(3'h0);
        give_verdict();
    end
endmodule : tb_hopping_encoder_control_store
